//--- hw/enc_pkg.sv
package enc_pkg;
   localparam int CLK_MHZ = 200;
   localparam int NV_WORDS = 12;
   localparam int WORD_W = 16;
   localparam int SEED0_IDX = 8;
   localparam int SEED1_IDX = 9;
   localparam int CFG_IDX = 11;
   localparam int CFG_TRIP_BIT = 12;
   localparam int CFG_RATE_BIT = 13;
   // Program entry window on the button-2 line, in microseconds
   localparam int ENTRY_MIN_US = 3500;
   localparam int ENTRY_MAX_US = 4500;
   // Basic pulse element, in microseconds
   localparam int TE_SLOW_US = 400;
   localparam int TE_FAST_US = 200;
   localparam int ENTRY_MIN_CYC = ENTRY_MIN_US * CLK_MHZ;
   localparam int ENTRY_MAX_CYC = ENTRY_MAX_US * CLK_MHZ;
   localparam int TE_SLOW_CYC = TE_SLOW_US * CLK_MHZ;
   localparam int TE_FAST_CYC = TE_FAST_US * CLK_MHZ;
   localparam int NV_WR_CYC = 16;
   localparam logic [15:0] NV_ERASED = 16'h0000;
   localparam logic [3:0] BTN_NONE = 4'h0;
   localparam logic [3:0] BTN_SEED = 4'hf;

   typedef enum logic [3:0] {
      ENC_IDLE = 4'b0001,
      ENC_ERASE = 4'b0010,
      ENC_PROG = 4'b0100,
      ENC_VERIFY = 4'b1000
   } enc_mode_e;

   function automatic logic [3:0] enc_map_buttons(input logic [2:0] b);
      logic [3:0] c;
      c = BTN_NONE;
      unique case (b)
         3'h0: c = BTN_NONE;
         3'h1: c = 4'h1;
         3'h2: c = 4'h2;
         3'h3: c = 4'h3;
         3'h4: c = 4'hc;
         3'h5: c = 4'he;
         3'h6: c = 4'he;
         3'h7: c = BTN_SEED;
      endcase
      return c;
   endfunction
endpackage

//--- hw/enc_top.sv
`timescale 1ns/100ps
module enc_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// How it works
// - Blanking sends every second code word only
// - Rate bit picks 400/200 us and blanking
// - All three buttons send the seed
// - Seed is two stored words, 32 bits
// - Battery-low flag rides every code word
// - Trip select bit picks battery threshold
// - Three button pins map to six codes
// - Session stores all 192 bits in array
// - Program entry clears whole array to zero
// - Words of 16 bits, sampled falling clock
// - Verify drives stored bits on falling clock
// - Verify only straight after full programming
module enc_top
   import enc_pkg::*;
#(
   parameter int ENTRY_MIN = ENTRY_MIN_CYC,
   parameter int ENTRY_MAX = ENTRY_MAX_CYC,
   parameter int TE_SLOW = TE_SLOW_CYC,
   parameter int TE_FAST = TE_FAST_CYC,
   parameter int WR_CYC = NV_WR_CYC,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic prog_clk,
   input wire logic button_in_0,
   input wire logic button_in_1,
   input wire logic button_in_2_prog_clock,
   input wire logic data_line_in,
   output logic data_line_out,
   output logic data_line_oe,
   input wire logic supply_below_low_trip,
   input wire logic supply_below_high_trip,
   input wire logic tx_word_start,
   output logic tx_active,
   output logic tx_word_send,
   output logic tx_seed_mode,
   output logic [31:0] tx_seed,
   output logic [3:0] tx_button_code,
   output logic battery_low_flag,
   output logic te_tick,
   output logic rate_select_bit,
   output logic low_trip_select,
   output logic alternate_word_blanking,
   output logic prog_mode,
   output logic erase_busy,
   output logic prog_ready,
   output logic verify_mode
);
   localparam int IW = $clog2(NV_WORDS);
   localparam logic [IW-1:0] LAST_IDX = IW'(NV_WORDS - 1);

   logic [WORD_W-1:0] nv_r [NV_WORDS];
   enc_mode_e mode_r;
   logic [5:0] s1_r;
   logic [5:0] s2_r;
   logic [19:0] hold_r;
   logic pwm_q_r;
   logic [IW-1:0] eidx_r;
   logic [IW-1:0] widx_r;
   logic [IW-1:0] ridx_r;
   logic [IW:0] wcnt_r;
   logic [$clog2(WR_CYC+1)-1:0] wbusy_r;
   logic s2_low_seen_r;
   logic link_clr_r;
   logic [2:0] tg_r;
   logic [WORD_W-1:0] rd_word_r;
   logic parity_r;
   logic [16:0] te_cnt_r;
   logic word_evt;
   logic entry_ok;
   logic [3:0] code;
   logic f_valid;
   logic f_ready;
   logic [WORD_W-1:0] f_data;
   logic wr_go;
   logic link_rst_n;

   // Link side, clocked by the programmer on its falling edge
   logic [3:0] lk_bit_r;
   logic [WORD_W-1:0] lk_sh_r;
   logic [WORD_W-1:0] lk_word_r;
   logic [WORD_W-1:0] lk_rd_r;
   logic lk_tgl_r;
   logic lk_dout_r;

   wire logic b0 = s2_r[0];
   wire logic b1 = s2_r[1];
   wire logic b2 = s2_r[2];
   wire logic din = s2_r[3];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= {supply_below_high_trip, supply_below_low_trip, data_line_in,
                  button_in_2_prog_clock, button_in_1, button_in_0};
         s2_r <= s1_r;
      end
   end

   assign link_rst_n = arst_n && !link_clr_r;

   always_ff @(negedge prog_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lk_bit_r <= '0;
         lk_sh_r <= '0;
         lk_word_r <= '0;
         lk_rd_r <= '0;
         lk_tgl_r <= 1'b0;
         lk_dout_r <= 1'b0;
      end else begin
         lk_bit_r <= lk_bit_r + 1'b1;
         lk_sh_r <= {data_line_in, lk_sh_r[WORD_W-1:1]};
         if (lk_bit_r == 4'hf) begin
            lk_word_r <= {data_line_in, lk_sh_r[WORD_W-1:1]};
            lk_tgl_r <= !lk_tgl_r;
         end
         // Least significant bit first in both directions
         if (lk_bit_r == 4'h0) begin
            lk_dout_r <= rd_word_r[0];
            lk_rd_r <= rd_word_r >> 1;
         end else begin
            lk_dout_r <= lk_rd_r[0];
            lk_rd_r <= lk_rd_r >> 1;
         end
      end
   end

   // Word-done toggle crosses in; the captured word is stable for 15 more link edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tg_r <= '0;
      end else begin
         tg_r <= {tg_r[1:0], lk_tgl_r};
      end
   end
   assign word_evt = tg_r[2] ^ tg_r[1];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_r <= '0;
         pwm_q_r <= 1'b0;
      end else begin
         pwm_q_r <= din;
         if (!b2) begin
            hold_r <= '0;
         end else if (hold_r != '1) begin
            hold_r <= hold_r + 1'b1;
         end
      end
   end
   assign entry_ok = b2 && din && !pwm_q_r && (hold_r >= 20'(ENTRY_MIN))
                     && (hold_r <= 20'(ENTRY_MAX));

   enc_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(word_evt && (mode_r == ENC_PROG)),
      .in_ready(prog_ready),
      .in_data(lk_word_r),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   // Array write is slow; the FIFO absorbs words while a write is still busy
   assign f_ready = (wbusy_r == '0) && (mode_r == ENC_PROG) && (wcnt_r < (IW+1)'(NV_WORDS));
   assign wr_go = f_valid && f_ready;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= ENC_IDLE;
         eidx_r <= '0;
         widx_r <= '0;
         wcnt_r <= '0;
         ridx_r <= '0;
         wbusy_r <= '0;
         s2_low_seen_r <= 1'b0;
         link_clr_r <= 1'b1;
      end else begin
         if (wbusy_r != '0) begin
            wbusy_r <= wbusy_r - 1'b1;
         end
         unique case (mode_r)
            ENC_IDLE: begin
               link_clr_r <= 1'b1;
               if (entry_ok) begin
                  mode_r <= ENC_ERASE;
                  eidx_r <= '0;
               end
            end
            ENC_ERASE: begin
               if (eidx_r == LAST_IDX) begin
                  mode_r <= ENC_PROG;
                  widx_r <= '0;
                  wcnt_r <= '0;
                  s2_low_seen_r <= 1'b0;
               end else begin
                  eidx_r <= eidx_r + 1'b1;
               end
            end
            ENC_PROG: begin
               // The entry hold ends with a falling clock; keep the link cleared past it
               if (!b2) begin
                  s2_low_seen_r <= 1'b1;
               end
               link_clr_r <= !(s2_low_seen_r || !b2);
               if (wr_go) begin
                  wbusy_r <= ($bits(wbusy_r))'(WR_CYC);
                  widx_r <= widx_r + 1'b1;
                  wcnt_r <= wcnt_r + 1'b1;
               end
               if (wcnt_r == (IW+1)'(NV_WORDS) && wbusy_r == '0) begin
                  mode_r <= ENC_VERIFY;
                  ridx_r <= '0;
               end
            end
            ENC_VERIFY: begin
               if (word_evt) begin
                  if (ridx_r == LAST_IDX) begin
                     mode_r <= ENC_IDLE;
                  end
                  ridx_r <= ridx_r + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NV_WORDS; i++) begin
            nv_r[i] <= NV_ERASED;
         end
      end else if (mode_r == ENC_ERASE) begin
         nv_r[eidx_r] <= NV_ERASED;
      end else if (wr_go) begin
         nv_r[widx_r] <= f_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_word_r <= '0;
      end else if (mode_r == ENC_VERIFY && ridx_r <= LAST_IDX) begin
         rd_word_r <= nv_r[ridx_r];
      end else begin
         rd_word_r <= '0;
      end
   end

   assign data_line_out = lk_dout_r;
   assign code = enc_map_buttons({b2, b1, b0});

   // Normal transmit control, only outside a programming session
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_active <= 1'b0;
         tx_button_code <= BTN_NONE;
         tx_seed_mode <= 1'b0;
         tx_seed <= '0;
         battery_low_flag <= 1'b0;
         rate_select_bit <= 1'b0;
         low_trip_select <= 1'b0;
         alternate_word_blanking <= 1'b0;
         prog_mode <= 1'b0;
         erase_busy <= 1'b0;
         verify_mode <= 1'b0;
         data_line_oe <= 1'b0;
      end else begin
         tx_active <= (mode_r == ENC_IDLE) && (code != BTN_NONE);
         tx_button_code <= code;
         tx_seed_mode <= (code == BTN_SEED);
         tx_seed <= {nv_r[SEED1_IDX], nv_r[SEED0_IDX]};
         rate_select_bit <= nv_r[CFG_IDX][CFG_RATE_BIT];
         low_trip_select <= nv_r[CFG_IDX][CFG_TRIP_BIT];
         alternate_word_blanking <= nv_r[CFG_IDX][CFG_RATE_BIT];
         battery_low_flag <= nv_r[CFG_IDX][CFG_TRIP_BIT] ? s2_r[5] : s2_r[4];
         prog_mode <= (mode_r == ENC_PROG);
         erase_busy <= (mode_r == ENC_ERASE);
         verify_mode <= (mode_r == ENC_VERIFY);
         data_line_oe <= (mode_r == ENC_VERIFY);
      end
   end

   // Blanking parity restarts with each transmission
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         parity_r <= 1'b0;
         tx_word_send <= 1'b0;
      end else if (!tx_active) begin
         parity_r <= 1'b0;
         tx_word_send <= 1'b0;
      end else if (tx_word_start) begin
         parity_r <= !parity_r;
         tx_word_send <= !(alternate_word_blanking && parity_r);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         te_cnt_r <= '0;
         te_tick <= 1'b0;
      end else begin
         te_tick <= 1'b0;
         if (!tx_active || te_cnt_r == '0) begin
            te_cnt_r <= rate_select_bit ? 17'(TE_FAST - 1) : 17'(TE_SLOW - 1);
            te_tick <= tx_active;
         end else begin
            te_cnt_r <= te_cnt_r - 1'b1;
         end
      end
   end
endmodule

//--- tb/enc_props.sv
`timescale 1ns/100ps
module enc_props
   import enc_pkg::*;
#(
   parameter int TE_SLOW = 80,
   parameter int TE_FAST = 40
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic supply_below_low_trip,
   input wire logic supply_below_high_trip,
   input wire logic tx_word_start,
   input wire logic tx_active,
   input wire logic tx_word_send,
   input wire logic tx_seed_mode,
   input wire logic [3:0] tx_button_code,
   input wire logic battery_low_flag,
   input wire logic te_tick,
   input wire logic rate_select_bit,
   input wire logic low_trip_select,
   input wire logic alternate_word_blanking,
   input wire logic prog_mode,
   input wire logic erase_busy,
   input wire logic verify_mode,
   input wire logic data_line_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [31:0] te_cnt_r;
   logic te_seen_r;
   logic prog_seen_r;
   // Period is only judged between two ticks of one transmission
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n || !tx_active) begin
         te_cnt_r <= '0;
         te_seen_r <= 1'b0;
      end else begin
         te_cnt_r <= te_tick ? '0 : te_cnt_r + 1;
         te_seen_r <= te_seen_r | te_tick;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n || erase_busy) prog_seen_r <= 1'b0;
      else if (prog_mode) prog_seen_r <= 1'b1;
   end
   property p_oe; data_line_oe |-> verify_mode; endproperty
   a_oe: assert property (p_oe) else $error("data line driven outside verify");
   property p_erase_len; $rose(erase_busy) |-> erase_busy[*8]; endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase too short");
   property p_erase_end; $fell(erase_busy) |-> ##[0:2] prog_mode; endproperty
   a_erase_end: assert property (p_erase_end) else $error("no program mode after erase");
   property p_one_mode; $onehot0({erase_busy, prog_mode, verify_mode}); endproperty
   a_one_mode: assert property (p_one_mode) else $error("two session modes at once");
   property p_verify_gate; $rose(verify_mode) |-> prog_seen_r; endproperty
   a_verify_gate: assert property (p_verify_gate) else $error("verify without program");
   property p_seed_code; tx_seed_mode |-> tx_button_code == BTN_SEED; endproperty
   a_seed_code: assert property (p_seed_code) else $error("seed mode with wrong code");
   property p_blank_tie; alternate_word_blanking == rate_select_bit; endproperty
   a_blank_tie: assert property (p_blank_tie) else $error("blanking not tied to rate");
   property p_all_words;
      tx_word_start && tx_active && !rate_select_bit |=> tx_word_send;
   endproperty
   a_all_words: assert property (p_all_words) else $error("slot blanked at slow rate");
   property p_te_period;
      te_tick && te_seen_r |-> te_cnt_r == (rate_select_bit ? TE_FAST : TE_SLOW) - 1;
   endproperty
   a_te_period: assert property (p_te_period) else $error("pulse element period wrong");
   property p_batt_hi;
      (low_trip_select && $stable(supply_below_high_trip))[*4]
         |-> battery_low_flag == supply_below_high_trip;
   endproperty
   a_batt_hi: assert property (p_batt_hi) else $error("battery flag, high point");
   property p_batt_lo;
      (!low_trip_select && $stable(supply_below_low_trip))[*4]
         |-> battery_low_flag == supply_below_low_trip;
   endproperty
   a_batt_lo: assert property (p_batt_lo) else $error("battery flag, low point");
   c_erase: cover property ($rose(erase_busy));
   c_verify: cover property ($rose(verify_mode));
   c_seed: cover property (tx_seed_mode);
   c_blank: cover property (tx_word_start && rate_select_bit);
endmodule
bind enc_top enc_props #(.TE_SLOW(TE_SLOW), .TE_FAST(TE_FAST)) u_props (.*);

//--- tb/enc_prog_model.sv
`timescale 1ns/100ps
module enc_prog_model (
   input wire logic clk,
   input wire logic dl,
   output logic b2,
   output logic pd,
   output logic poe
);
   initial begin
      b2 = 1'b0;
      pd = 1'b0;
      poe = 1'b0;
   end
   task automatic enter(input int n);
      b2 <= 1'b1;
      repeat (n) @(posedge clk);
      poe <= 1'b1;
      pd <= 1'b1;
   endtask
   task automatic leave();
      b2 <= 1'b0;
      pd <= 1'b0;
   endtask
   // 64 ns link clock, offset from the system clock; data moves on the high phase
   task automatic send(input logic [15:0] w);
      #3;
      for (int i = 0; i < 16; i++) begin
         b2 = 1'b1;
         pd = w[i];
         #32 b2 = 1'b0;
         #32;
      end
      repeat (40) @(posedge clk);
   endtask
   task automatic read(output logic [15:0] w);
      poe = 1'b0;
      #3;
      for (int i = 0; i < 16; i++) begin
         b2 = 1'b1;
         #32 b2 = 1'b0;
         #16 w[i] = dl;
         #16;
      end
   endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import enc_pkg::*;
   localparam logic [3:0] MAP [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'he, 4'he, 4'hf};
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic b0 = 1'b0, b1 = 1'b0, b2t = 1'b0, lo = 1'b0, hi = 1'b0, ws = 1'b0;
   logic b2m, b2, pd, poe, dl, dl_out, dl_oe;
   logic act, snd, sm, bat, te, rate, trip, blank, pm, eb, rdy, vm;
   logic [31:0] seed_o;
   logic [3:0] code;
   logic [15:0] w [12];
   logic [15:0] r;
   int fails = 0, cmp_count = 0, seed = 78, n, c;
   assign b2 = b2m | b2t;
   // Released data line is pulled low so entry cannot happen by accident
   assign dl = dl_oe ? dl_out : (poe & pd);
   always #2.5 clk = ~clk;
   enc_prog_model pm_i (.clk(clk), .dl(dl), .b2(b2m), .pd(pd), .poe(poe));
   enc_top #(.ENTRY_MIN(70), .ENTRY_MAX(90), .TE_SLOW(80), .TE_FAST(40)) dut (
      .clk(clk), .arst_n(arst_n), .prog_clk(b2), .button_in_0(b0), .button_in_1(b1),
      .button_in_2_prog_clock(b2), .data_line_in(dl), .data_line_out(dl_out),
      .data_line_oe(dl_oe), .supply_below_low_trip(lo), .supply_below_high_trip(hi),
      .tx_word_start(ws), .tx_active(act), .tx_word_send(snd), .tx_seed_mode(sm),
      .tx_seed(seed_o), .tx_button_code(code), .battery_low_flag(bat), .te_tick(te),
      .rate_select_bit(rate), .low_trip_select(trip), .alternate_word_blanking(blank),
      .prog_mode(pm), .erase_busy(eb), .prog_ready(rdy), .verify_mode(vm));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic wait_for(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic slots(input logic [3:0] exp);
      for (int k = 0; k < 4; k++) begin
         ws <= 1'b1;
         @(posedge clk);
         ws <= 1'b0;
         repeat (3) @(posedge clk);
         chk(snd, exp[k], "slot send");
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #300000;
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 1; i < 8; i++) begin
         n = $random(seed);
         {b2t, b1, b0} <= i[2:0];
         {hi, lo} <= n[1:0];
         repeat (6) @(posedge clk);
         chk(code, MAP[i], "button code");
         chk(sm, i == 7, "seed mode");
         chk(bat, lo, "battery flag, low point");
      end
      {b2t, b1, b0} <= 3'b001;
      repeat (6) @(posedge clk);
      slots(4'b1111);
      repeat (200) @(posedge clk);
      {b2t, b1, b0} <= 3'b000;
      repeat (20) @(posedge clk);
      $display("test buttons done");
      pm_i.read(r);
      chk({vm, dl_oe}, 2'b00, "verify before program");
      $display("test refusal done");
      pm_i.enter(80);
      wait_for(eb, 20);
      c = 0;
      while (eb === 1'b1 && c < 40) begin
         @(posedge clk);
         c++;
      end
      chk(c, 12, "erase length");
      wait_for(pm, 10);
      chk(pm, 1'b1, "program mode");
      chk({rate, trip, blank}, 3'b000, "erased config");
      chk(rdy, 1'b1, "fifo ready in program mode");
      pm_i.leave();
      // Button-2 must be seen low before the first clock, or bit 0 is swallowed
      repeat (20) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
         w[i] = $random(seed);
         if (i == 11) w[i][15:12] = 4'b0011;
         pm_i.send(w[i]);
      end
      wait_for(vm, 400);
      chk(vm, 1'b1, "verify mode");
      for (int i = 0; i < 12; i++) begin
         pm_i.read(r);
         chk(r, w[i], "read back word");
      end
      repeat (10) @(posedge clk);
      chk({vm, dl_oe}, 2'b00, "session over");
      chk({rate, trip, blank}, 3'b111, "config bits");
      chk(seed_o, {w[9], w[8]}, "seed value");
      $display("test program done");
      for (int k = 0; k < 4; k++) begin
         {hi, lo} <= k[1:0];
         repeat (6) @(posedge clk);
         chk(bat, hi, "battery flag, high point");
      end
      {b2t, b1, b0} <= 3'b111;
      repeat (6) @(posedge clk);
      chk(sm, 1'b1, "seed transmission");
      {b2t, b1, b0} <= 3'b001;
      repeat (6) @(posedge clk);
      slots(4'b0101);
      repeat (200) @(posedge clk);
      $display("test transmit done");
      report_and_stop();
   end
endmodule
